/* rtl/dcm_regs.vh */
// Constants for the DAC clock multiplier control block.
// Assumes the includer uses a 10 MHz system clock and a serial register port.
// How it works
// RULE1: Enable bit high selects multiplier sample clock.
// RULE2: Enable bit low passes reference clock directly.
// RULE3: Oscillator runs at reference times both ratios.
// RULE4: Sample clock is reference times multiplier ratio.
// RULE5: Host keeps oscillator between one and two GHz.
// RULE6: Ratio fields sit at bits 14:13, 12:11.
// RULE7: Band field bits 7:2; code 63 searches.
// RULE8: Other band codes pick one fixed band.
// RULE9: Auto search finds band; readback returns it.
// RULE10: Lock drives status bit 3 and pin.
// RULE11: Host expects lock within five milliseconds.
// RULE12: Host programs recommended bias field values.
// RULE13: Host sets ratios and bias before auto.
// RULE14: Host keeps reference clock running throughout.
// RULE15: Host offsets readback band for temperature.
// RULE16: Host writes adjusted band back to fix.
// RULE17: Lock reads low when disabled, unlocked, searching.
// RULE18: Ratio code mapping is an implementation parameter.
`ifndef DCM_REGS_VH
`define DCM_REGS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DCM_ADDR_W          5
`define DCM_ADDR_CTRL       5'h04
`define DCM_ADDR_STATUS     5'h09

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define DCM_CTRL_RESET      32'h00000000
`define DCM_BW_HI           20
`define DCM_BW_LO           16
`define DCM_EN_BIT          15
`define DCM_N1_HI           14
`define DCM_N1_LO           13
`define DCM_N2_HI           12
`define DCM_N2_LO           11
`define DCM_BIAS_HI         10
`define DCM_BIAS_LO         8
`define DCM_BAND_HI         7
`define DCM_BAND_LO         2
`define DCM_DRV_HI          1
`define DCM_DRV_LO          0
`define DCM_CTRL_MASK       32'h001FFFFF
`define DCM_BAND_AUTO       6'h3F
`define DCM_BAND_LAST       6'h3E
`define DCM_BAND_FIRST      6'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define DCM_LOCK_BIT        3

// ----------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------
`define DCM_INSTR_BITS      6'h08
`define DCM_FRAME_BITS      6'h28
`define DCM_READ_BIT        7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCM_CLK_NS          100
`define DCM_SETTLE_NS       20000

`endif

/* rtl/dcm_band_search.v */
// Automatic oscillator band search engine.
// Assumes i_lock is already synchronised to i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "dcm_regs.vh"

module dcm_band_search #(
  parameter [15:0] SETTLE_CYC = 16'h00C8
) (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_ce,
  input  wire       i_start,
  input  wire       i_lock,
  output reg  [5:0] o_band,
  output reg        o_found
);

  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_SETTLE = 2'b01;
  localparam [1:0] ST_CHECK  = 2'b10;
  localparam [1:0] ST_DONE   = 2'b11;

  reg [1:0]  state_r;
  reg [15:0] wait_r;

  // Each band is applied, given time to settle, then tested for lock.
  // After the last band the sweep wraps, so a late reference still locks.
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
      wait_r  <= 16'h0000;
      o_band  <= `DCM_BAND_FIRST;
      o_found <= 1'b0;
    end else if (i_ce) begin
      if (!i_start) begin
        state_r <= ST_IDLE;
        o_found <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            o_band  <= `DCM_BAND_FIRST;
            wait_r  <= SETTLE_CYC;
            state_r <= ST_SETTLE;
          end
          ST_SETTLE: begin
            if (wait_r == 16'h0001) begin
              state_r <= ST_CHECK;
            end else begin
              wait_r <= wait_r - 16'h0001;
            end
          end
          ST_CHECK: begin
            if (i_lock) begin
              o_found <= 1'b1; // [RULE9]
              state_r <= ST_DONE;
            end else begin
              if (o_band == `DCM_BAND_LAST) begin
                o_band <= `DCM_BAND_FIRST;
              end else begin
                o_band <= o_band + 6'h01; // [RULE8]
              end
              wait_r  <= SETTLE_CYC;
              state_r <= ST_SETTLE;
            end
          end
          ST_DONE: begin
            state_r <= ST_DONE;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // dcm_band_search
`default_nettype wire

/* rtl/dcm_ctrl.v */
// Control logic for the DAC clock multiplier: serial register port,
// control and status registers, band search and lock reporting.
// Assumes a slow serial clock (well under a quarter of i_clk) and an
// analog multiplier that reports lock asynchronously on i_pll_locked.
`timescale 1ns/1ns
`default_nettype none
`include "dcm_regs.vh"

module dcm_ctrl #(
  parameter [15:0] N1_MAP = 16'h8421,
  parameter [15:0] N2_MAP = 16'h8421
) (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_ce,
  input  wire       i_sclk,
  input  wire       i_cs_n,
  input  wire       i_sdi,
  output wire       o_sdo,
  output reg        o_sdo_oe,
  input  wire       i_pll_locked,
  output reg        o_use_multiplier,
  output reg  [7:0] o_vco_mult,
  output reg  [3:0] o_dac_mult,
  output reg  [1:0] o_vco_divider_ratio,
  output reg  [1:0] o_reference_multiplier_ratio,
  output reg  [4:0] o_loop_bw,
  output reg  [2:0] o_bias,
  output reg  [1:0] o_vco_drive,
  output reg  [5:0] o_vco_band,
  output reg        o_pll_lock
);

  localparam [31:0] SETTLE_W =
    (`DCM_SETTLE_NS + `DCM_CLK_NS - 1) / `DCM_CLK_NS;
  localparam [15:0] SETTLE_CYC = SETTLE_W[15:0];

  // --------------------------------------------------------------------
  // Ratio decoding
  // --------------------------------------------------------------------
  // Picks the 4-bit ratio for a 2-bit code from a packed map.
  function [3:0] ratio_of;
    input [15:0] map;
    input [1:0]  code;
    begin
      ratio_of = map[code*4 +: 4]; // [RULE18]
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg  [1:0] sclk_s_r;
  reg  [1:0] cs_s_r;
  reg  [1:0] sdi_s_r;
  reg        sclk_d_r;
  reg  [1:0] lock_s_r;

  // Every pin passes two flops first; the serial clock edge is found one
  // flop later, so a rising pin edge is acted on three cycles after it.
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      sclk_s_r <= 2'b00;
      cs_s_r   <= 2'b11;
      sdi_s_r  <= 2'b00;
      sclk_d_r <= 1'b0;
      lock_s_r <= 2'b00;
    end else if (i_ce) begin
      sclk_s_r <= {sclk_s_r[0], i_sclk};
      cs_s_r   <= {cs_s_r[0], i_cs_n};
      sdi_s_r  <= {sdi_s_r[0], i_sdi};
      sclk_d_r <= sclk_s_r[1];
      lock_s_r <= {lock_s_r[0], i_pll_locked};
    end
  end

  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire cs_active = ~cs_s_r[1];
  wire lock_sync = lock_s_r[1];

  // --------------------------------------------------------------------
  // Registers and serial frame
  // --------------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [5:0]  bitcnt_r;
  reg  [7:0]  instr_r;
  reg  [31:0] rx_r;
  reg  [31:0] tx_r;
  reg         auto_r;
  reg         lock_r;

  wire [5:0] srch_band;
  wire       srch_found;

  wire [5:0] band_field = ctrl_r[`DCM_BAND_HI:`DCM_BAND_LO];
  wire       enabled    = ctrl_r[`DCM_EN_BIT];
  wire [7:0] instr_nxt  = {instr_r[6:0], sdi_s_r[1]};
  wire [31:0] rx_nxt    = {rx_r[30:0], sdi_s_r[1]};

  // Readback of the band field shows the band the search settled on.
  wire [5:0] band_rd = (auto_r && srch_found) ? srch_band // [RULE9]
                                              : band_field;

  // Returns the read data for an address; unmapped reads give zero.
  // Status is read-only, so a write to it is dropped.
  function [31:0] read_data;
    input [`DCM_ADDR_W-1:0] addr;
    reg   [31:0]            d;
    begin
      d = 32'h00000000;
      if (addr == `DCM_ADDR_CTRL) begin
        d = ctrl_r;
        d[`DCM_BAND_HI:`DCM_BAND_LO] = band_rd;
      end else if (addr == `DCM_ADDR_STATUS) begin
        d[`DCM_LOCK_BIT] = lock_r; // [RULE10]
      end
      read_data = d;
    end
  endfunction

  assign o_sdo = tx_r[31];

  // The bit counter stops at the frame length, so trailing clocks are
  // ignored, and a frame cut short by chip select never reaches a commit.
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_r   <= `DCM_CTRL_RESET;
      bitcnt_r <= 6'h00;
      instr_r  <= 8'h00;
      rx_r     <= 32'h00000000;
      tx_r     <= 32'h00000000;
      o_sdo_oe <= 1'b0;
      auto_r   <= 1'b0;
    end else if (i_ce) begin
      if (!cs_active) begin
        bitcnt_r <= 6'h00;
        o_sdo_oe <= 1'b0;
      end else if (sclk_rise && bitcnt_r != `DCM_FRAME_BITS) begin
        bitcnt_r <= bitcnt_r + 6'h01;
        if (bitcnt_r < `DCM_INSTR_BITS) begin
          instr_r <= instr_nxt;
          if (bitcnt_r == `DCM_INSTR_BITS - 6'h01 &&
              instr_nxt[`DCM_READ_BIT]) begin
            tx_r     <= read_data(instr_nxt[`DCM_ADDR_W-1:0]);
            o_sdo_oe <= 1'b1;
          end
        end else begin
          rx_r <= rx_nxt;
          tx_r <= {tx_r[30:0], 1'b0};
          if (bitcnt_r == `DCM_FRAME_BITS - 6'h01) begin
            o_sdo_oe <= 1'b0;
            if (!instr_r[`DCM_READ_BIT] &&
                instr_r[`DCM_ADDR_W-1:0] == `DCM_ADDR_CTRL) begin
              // Writing 63 starts a search with the fields as they stand;
              // any other band code fixes that band.
              ctrl_r <= rx_nxt & `DCM_CTRL_MASK; // [RULE6] [RULE7] [RULE16]
              auto_r <= (rx_nxt[`DCM_BAND_HI:`DCM_BAND_LO] ==
                         `DCM_BAND_AUTO); // [RULE13]
            end
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Band search
  // --------------------------------------------------------------------
  // The search runs only while enabled and in automatic mode.
  dcm_band_search #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_search (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_start   (auto_r & enabled),
    .i_lock    (lock_sync),
    .o_band    (srch_band),
    .o_found   (srch_found)
  );

  // --------------------------------------------------------------------
  // Outputs to the analog multiplier and lock reporting
  // --------------------------------------------------------------------
  // Every output is registered, so each follows its source one clock
  // later; pin and status bit share one expression and never disagree.
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      lock_r                       <= 1'b0;
      o_pll_lock                   <= 1'b0;
      o_use_multiplier             <= 1'b0;
      o_vco_mult                   <= 8'h00;
      o_dac_mult                   <= 4'h0;
      o_vco_divider_ratio          <= 2'b00;
      o_reference_multiplier_ratio <= 2'b00;
      o_loop_bw                    <= 5'h00;
      o_bias                       <= 3'h0;
      o_vco_drive                  <= 2'b00;
      o_vco_band                   <= 6'h00;
    end else if (i_ce) begin
      // Low while disabled, searching or out of lock.
      lock_r     <= enabled & lock_sync & (~auto_r | srch_found); // [RULE17]
      o_pll_lock <= enabled & lock_sync & (~auto_r | srch_found); // [RULE10]
      // Low bypasses the multiplier: reference clock is the sample clock.
      o_use_multiplier <= enabled; // [RULE1] [RULE2]
      o_vco_mult <= ratio_of(N1_MAP, ctrl_r[`DCM_N1_HI:`DCM_N1_LO]) *
                    ratio_of(N2_MAP, ctrl_r[`DCM_N2_HI:`DCM_N2_LO]); // [RULE3]
      o_dac_mult <= enabled ?
                    ratio_of(N2_MAP, ctrl_r[`DCM_N2_HI:`DCM_N2_LO]) :
                    4'h1; // [RULE4]
      o_vco_divider_ratio          <= ctrl_r[`DCM_N1_HI:`DCM_N1_LO];
      o_reference_multiplier_ratio <= ctrl_r[`DCM_N2_HI:`DCM_N2_LO];
      o_loop_bw   <= ctrl_r[`DCM_BW_HI:`DCM_BW_LO];
      o_bias      <= ctrl_r[`DCM_BIAS_HI:`DCM_BIAS_LO];
      o_vco_drive <= ctrl_r[`DCM_DRV_HI:`DCM_DRV_LO];
      o_vco_band  <= auto_r ? srch_band : band_field; // [RULE8]
    end
  end

endmodule // dcm_ctrl
`default_nettype wire

/* sim/dcm_ctrl_monitor.sv */
// Assertions on the clock multiplier control ports.
// Assumes the default ratio maps, where codes 0..3 mean 1, 2, 4, 8.
`timescale 1ns/1ns
`default_nettype none
module dcm_ctrl_chk (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_cs_n,
  input wire logic       i_pll_locked,
  input wire logic       o_sdo_oe,
  input wire logic       o_use_multiplier,
  input wire logic [7:0] o_vco_mult,
  input wire logic [3:0] o_dac_mult,
  input wire logic [1:0] o_vco_divider_ratio,
  input wire logic [1:0] o_reference_multiplier_ratio,
  input wire logic [5:0] o_vco_band,
  input wire logic       o_pll_lock
);
  logic [1:0] up = 2'h0;
  // Outputs trail reset release by a stage, so checks start later.
  always @(posedge i_clk) up <= !i_reset_n ? 2'h0 : up + {1'b0, up != 2'h3};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n || up != 2'h3);
  property p_byp; !o_use_multiplier |-> o_dac_mult == 4'h1; endproperty
  a_byp: assert property (p_byp)
    else $error("dac ratio not 1 in bypass");
  property p_vco;
    o_vco_mult == 8'h1 << ({1'b0, o_vco_divider_ratio}
                           + o_reference_multiplier_ratio);
  endproperty
  a_vco: assert property (p_vco)
    else $error("vco ratio wrong");
  property p_dac;
    o_use_multiplier |-> o_dac_mult == 4'h1 << o_reference_multiplier_ratio;
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac ratio wrong");
  property p_band; o_vco_band != 6'h3F; endproperty
  a_band: assert property (p_band)
    else $error("auto code applied as band");
  property p_hold;
    i_cs_n [*8] ##0 (!o_use_multiplier && !$past(o_use_multiplier))
      |-> $stable(o_vco_band);
  endproperty
  a_hold: assert property (p_hold)
    else $error("band moved without a write");
  property p_len;
    o_pll_lock |-> o_use_multiplier || $past(o_use_multiplier);
  endproperty
  a_len: assert property (p_len)
    else $error("lock while disabled");
  property p_lin; !i_pll_locked [*8] |-> !o_pll_lock; endproperty
  a_lin: assert property (p_lin)
    else $error("lock pin without analog lock");
  property p_oe; i_cs_n [*6] |-> !o_sdo_oe; endproperty
  a_oe: assert property (p_oe)
    else $error("sdo driven while deselected");
  c_lock: cover property ($rose(o_pll_lock));
  c_oe: cover property ($rose(o_sdo_oe));
  c_off: cover property ($fell(o_use_multiplier));
endmodule // dcm_ctrl_chk
bind dcm_ctrl dcm_ctrl_chk dcm_ctrl_chk_i (.i_clk, .i_reset_n, .i_cs_n,
  .i_pll_locked, .o_sdo_oe, .o_use_multiplier, .o_vco_mult, .o_dac_mult,
  .o_vco_divider_ratio, .o_reference_multiplier_ratio, .o_vco_band,
  .o_pll_lock);
`default_nettype wire

/* sim/dcm_host_model.sv */
// Serial host and analog lock source for the multiplier control block.
// Assumes inputs change at the falling edge of the 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module dcm_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_sdo,
  input  wire logic       i_use,
  input  wire logic [5:0] i_band,
  input  wire logic [5:0] i_lock_band,
  output var  logic       o_sclk,
  output var  logic       o_cs_n,
  output var  logic       o_sdi,
  output var  logic       o_locked
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_locked = 1'b0;
  end
  // The oscillator locks only while in use and in the one band given on i_lock_band.
  always @(negedge i_clk) o_locked <= i_use && i_band == i_lock_band;
  // One frame; the serial clock rests low between frames.
  task automatic frame(input logic [7:0] ins, input logic [31:0] wd,
                       output logic [31:0] rd);
    logic [39:0] b;
    b = {ins, wd};
    rd = 32'h0;
    o_cs_n = 1'b0;
    for (int i = 0; i < 40; i++) begin
      o_sdi = b[39 - i];
      repeat (4) @(negedge i_clk);
      if (i >= 8) rd[39 - i] = i_sdo;
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_sdi = ~o_sdi;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule // dcm_host_model
`default_nettype wire

/* sim/dcm_ctrl_test.sv */
// Self-checking bench for the clock multiplier control block.
// Assumes the default ratio maps, where codes 0..3 mean 1, 2, 4, 8.
`timescale 1ns/1ns
`default_nettype none
module dcm_ctrl_test;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_sclk, i_cs_n, i_sdi;
  logic        o_sdo, i_pll_locked, o_use_multiplier, o_pll_lock;
  logic        i_ce = 1'b1, o_sdo_oe;
  logic [7:0]  o_vco_mult;
  logic [3:0]  o_dac_mult;
  logic [1:0]  o_vco_divider_ratio, o_reference_multiplier_ratio, o_vco_drive;
  logic [4:0]  o_loop_bw;
  logic [2:0]  o_bias;
  logic [5:0]  o_vco_band, bnd, lk_band = 6'h3E;
  logic [31:0] rd, wd;
  integer      seed = 32'h113C, err_total = 0, comparisons = 0;
  dcm_ctrl dcm_ctrl_i (.i_clk, .i_reset_n, .i_ce, .i_sclk, .i_cs_n,
    .i_sdi, .o_sdo, .o_sdo_oe, .i_pll_locked, .o_use_multiplier,
    .o_vco_mult, .o_dac_mult, .o_vco_divider_ratio, .o_loop_bw, .o_bias,
    .o_reference_multiplier_ratio, .o_vco_drive, .o_vco_band, .o_pll_lock);
  dcm_host_model host_i (.i_clk, .i_sdo(o_sdo), .i_use(o_use_multiplier),
    .i_band(o_vco_band), .i_lock_band(lk_band), .o_sclk(i_sclk),
    .o_cs_n(i_cs_n), .o_sdi(i_sdi), .o_locked(i_pll_locked));
  initial forever #50 i_clk = ~i_clk;
  task automatic check(input string s, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [3:0] exp_dac(input logic [31:0] c);
    return c[15] ? 4'h1 << c[12:11] : 4'h1;
  endfunction
  task automatic xfer(input logic [7:0] ins, input logic [31:0] d);
    host_i.frame(ins, d, rd);
  endtask
  task automatic outs(input logic [31:0] c, input logic lk);
    check("use", o_use_multiplier, c[15]);
    check("dac", o_dac_mult, exp_dac(c));
    check("vco", o_vco_mult,
          8'h1 << ({1'b0, c[14:13]} + c[12:11]));
    check("oe", o_sdo_oe, 1'b0);
    check("ratio", {o_vco_divider_ratio, o_reference_multiplier_ratio},
          c[14:11]);
    check("bias", {o_loop_bw, o_bias, o_vco_drive},
          {c[20:16], c[10:8], c[1:0]});
    check("band", o_vco_band, c[7:2]);
    check("pin", o_pll_lock, lk);
    xfer(8'h89, 32'h0);
    check("status", rd, {28'h0, lk, 3'h0});
    xfer(8'h84, 32'h0);
    check("ctrl", rd, c & 32'h001FFFFF);
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    xfer(8'h84, 32'h0);
    check("reset", rd, 32'h0);
    xfer(8'h9F, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wd = k == 0 ? 32'hFFFFFFFF : k == 1 ? 32'h0 : $random(seed);
      if (wd[7:2] == 6'h3F) wd[7:2] = 6'h3E;
      xfer(8'h04, wd);
      xfer(8'h09, ~wd);
      outs(wd, wd[15] && wd[7:2] == lk_band);
    end
    for (int k = 0; k < 2; k++) begin
      lk_band = k ? 6'h3E : 6'h2 + {$random(seed)} % 60;
      wd = {11'h0, 5'h0F, 1'b1, 2'h1, 2'h1, 3'h3,
            6'h0, 2'h3};
      xfer(8'h04, wd);
      wd[7:2] = 6'h3F;
      xfer(8'h04, wd);
      check("seek pin", o_pll_lock, 1'b0);
      xfer(8'h84, 32'h0);
      check("seek band", rd[7:2], 6'h3F);
      i_ce = 1'b0;
      bnd = o_vco_band;
      repeat (400) @(negedge i_clk);
      check("freeze", o_vco_band, bnd);
      i_ce = 1'b1;
      for (int t = 0; t < 50000 && o_pll_lock !== 1'b1; t++)
        @(negedge i_clk);
      if (o_pll_lock !== 1'b1) begin
        err_total++;
        break;
      end
      xfer(8'h84, 32'h0);
      check("found", rd[7:2], lk_band);
      wd[7:2] = lk_band;
      xfer(8'h04, wd);
      outs(wd, 1'b1);
    end
    wd[15] = 1'b0;
    xfer(8'h04, wd);
    outs(wd, 1'b0);
    tally_and_finish;
  end
endmodule // dcm_ctrl_test
`default_nettype wire
